// ---- common/pvic_defines.svh ----
// Constants of the priority vector interrupt controller
`ifndef PVIC_DEFINES_SVH
`define PVIC_DEFINES_SVH
`define PVIC_NSRC       118
`define PVIC_NTRAP      8
`define PVIC_DEF_BASE   24'h000004
`define PVIC_ALT_BASE   24'h000104
`define PVIC_RESET_ADDR 24'h000000
`define PVIC_ALT_BIT    15
`define PVIC_PRIO_RST   3'h4
`define PVIC_USER_MAX   3'h7
`define PVIC_VEC_OSC    1
`define PVIC_VEC_ADDR   2
`define PVIC_VEC_STACK  3
`define PVIC_VEC_MATH   4
`define PVIC_LVL_OSC    4'hE
`define PVIC_LVL_ADDR   4'hD
`define PVIC_LVL_STACK  4'hC
`define PVIC_LVL_MATH   4'hB
`define PVIC_LVL_NONE   4'h0
`endif

// ---- common/pvic_pkg.sv ----
// Types of the priority vector interrupt controller
package pvic_pkg;
  typedef logic [3:0]  pvic_lvl_t;   // Four-bit core or trap level
  typedef logic [2:0]  pvic_ulvl_t;  // Three-bit user level
  typedef logic [23:0] pvic_addr_t;  // Handler address
endpackage : pvic_pkg

// ---- common/pvic_arb_if.sv ----
// Interface between the controller and its arbiter
`timescale 1ns/1ns
`default_nettype none
interface pvic_arb_if #(
  parameter int N  = 126,
  parameter int VW = 7
);
  logic [N-1:0]      pend;     // Pending requests by vector
  logic [N-1:0][3:0] lvl;      // Level of each vector
  logic              valid;    // A takeable request exists
  logic [VW-1:0]     win;      // Winning vector number
  logic [3:0]        win_lvl;  // Level of the winner
  modport arb (input pend, lvl, output valid, win, win_lvl);
  modport ctl (output pend, lvl, input valid, win, win_lvl);
endinterface : pvic_arb_if
`default_nettype wire

// ---- design/pvic_arbiter.sv ----
// Level then natural-order arbiter of the interrupt controller
`timescale 1ns/1ns
`default_nettype none
`include "pvic_defines.svh"
module pvic_arbiter
  import pvic_pkg::*;
#(
  parameter int N  = 126,
  parameter int VW = 7
) (
  pvic_arb_if.arb a
);

  pvic_lvl_t     best_lvl;  // Best level seen so far
  logic [VW-1:0] best;      // Vector holding it
  logic          found;     // Any takeable request

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // Scan from the last vector down so that ties go to the lower number
  always_comb begin
    best_lvl = `PVIC_LVL_NONE;
    best     = '0;
    found    = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      // Level zero never qualifies level first, then order
      if (a.pend[i] && a.lvl[i] != `PVIC_LVL_NONE && a.lvl[i] >= best_lvl) begin
        best_lvl = a.lvl[i];
        best     = VW'(i);
        found    = 1'b1;
      end
    end
    a.valid   = found;
    a.win     = best;
    a.win_lvl = best_lvl;
  end
endmodule : pvic_arbiter
`default_nettype wire

// ---- design/pvic_top.sv ----
// Priority vector interrupt controller, top level
// How it works
// - All pending requests merge into one request
// - Default table at 0x000004, 126 entries
// - Each entry gives a 24-bit handler address
// - Alternate select bit 15 switches tables
// - Alternate table starts at 0x000104, same layout
// - Traps 0-7 at consecutive even addresses
// - Reset clears all registers but source levels, no vector fetch
// - Sixteen core levels; request must exceed
// - Users levels 0-7, traps 8-15, unique
// - Level zero source is never taken
// - Core level: three low bits plus top
// - Low bits writable; 111 blocks users
// - Top bit set by traps, software clears only
// - Nesting disabled makes low bits read-only
// - Three-bit field per nibble, bit3 zero
// - User levels run 1 lowest to 7
// - Source levels reset to four
// - Rank by level, then lower vector wins
// - Only strictly higher level preempts
// - Trap levels fixed at 14,13,12,11
// - Soft traps sampled over two cycles
`timescale 1ns/1ns
`default_nettype none
`include "pvic_defines.svh"
module pvic_top
  import pvic_pkg::*;
#(
  parameter int NSRC = `PVIC_NSRC,
  parameter int SW   = $clog2(`PVIC_NSRC),
  parameter int N    = `PVIC_NSRC + `PVIC_NTRAP,
  parameter int VW   = $clog2(`PVIC_NSRC + `PVIC_NTRAP)
) (
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire logic            ce,
  input  wire logic [NSRC-1:0] src_pend,
  input  wire logic            trap_osc_fail,
  input  wire logic            trap_addr_err,
  input  wire logic            trap_stack_err,
  input  wire logic            trap_math_err,
  input  wire logic            prio_wr_en,
  input  wire logic [SW-1:0]   prio_wr_idx,
  input  wire logic [3:0]      prio_wr_data,
  input  wire logic [SW-1:0]   prio_rd_idx,
  output var  logic [3:0]      prio_rd_data,
  input  wire logic            ctl2_wr_en,
  input  wire logic [15:0]     ctl2_wr_data,
  output logic      [15:0]     int_control_two,
  input  wire logic            ipl_wr_en,
  input  wire logic [2:0]      ipl_wr_data,
  input  wire logic            ipl_top_clr,
  input  wire logic            nest_disable,
  output var  pvic_ulvl_t      core_priority_low,
  output var  logic            core_priority_top,
  input  wire logic            exc_ack,
  input  wire logic            ret_en,
  input  wire logic [3:0]      ret_prio,
  output logic                 exc_req,
  output var  logic [VW-1:0]   exc_vector,
  output var  pvic_addr_t      exc_addr,
  output var  pvic_lvl_t       exc_level,
  output logic      [23:0]     restart_addr
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pvic_ulvl_t      prio      [NSRC];  // Source levels, one per nibble
  pvic_ulvl_t      next_prio [NSRC];
  logic [3:0]      next_prio_rd;      // Read data for the nibble
  logic            alt_sel;           // Alternate table select
  logic            next_alt_sel;
  pvic_ulvl_t      next_low;          // Core level, low bits
  logic            next_top;          // Core level, top bit
  logic [1:0]      soft_s1;           // Soft traps, first sample
  logic [1:0]      soft_s2;           // Soft traps, second sample
  logic [1:0]      next_s1;
  logic [1:0]      next_s2;
  logic            win_valid;         // Registered arbitration result
  logic            next_valid;
  logic [VW-1:0]   next_vec;
  pvic_addr_t      next_addr;
  pvic_lvl_t       next_lvl;
  pvic_lvl_t       core_prio;         // Full four-bit core level
  pvic_addr_t      base;              // Active table base

  pvic_arb_if #(.N(N), .VW(VW)) arb ();

  pvic_arbiter #(.N(N), .VW(VW)) u_arb (
    .a (arb.arb)
  );

  // Core level seen as one value
  assign core_prio       = {core_priority_top, core_priority_low};
  assign int_control_two = {alt_sel, 15'h0000};
  assign restart_addr    = `PVIC_RESET_ADDR;  // Reset starts here, no fetch

  // ----------------------------------------------------------------
  // Arbiter inputs
  // ----------------------------------------------------------------
  // Traps sit at their fixed vectors and levels, sources follow them
  always_comb begin
    arb.pend = '0;
    arb.lvl  = '0;
    arb.pend[`PVIC_VEC_OSC]   = trap_osc_fail;
    arb.pend[`PVIC_VEC_ADDR]  = trap_addr_err;
    arb.pend[`PVIC_VEC_STACK] = soft_s2[0];
    arb.pend[`PVIC_VEC_MATH]  = soft_s2[1];
    arb.lvl[`PVIC_VEC_OSC]    = `PVIC_LVL_OSC;
    arb.lvl[`PVIC_VEC_ADDR]   = `PVIC_LVL_ADDR;
    arb.lvl[`PVIC_VEC_STACK]  = `PVIC_LVL_STACK;
    arb.lvl[`PVIC_VEC_MATH]   = `PVIC_LVL_MATH;
    for (int k = 0; k < NSRC; k++) begin
      arb.pend[`PVIC_NTRAP + k] = src_pend[k];
      arb.lvl[`PVIC_NTRAP + k]  = {1'b0, prio[k]};       // Users stay below 8
    end
  end

  // ----------------------------------------------------------------
  // Soft trap sampling
  // ----------------------------------------------------------------
  // Two stages delay stack and math traps like interrupts
  always_comb begin
    next_s1 = {trap_math_err, trap_stack_err};
    next_s2 = soft_s1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      soft_s1 <= 2'h0;
      soft_s2 <= 2'h0;
    end else if (ce) begin
      soft_s1 <= next_s1;
      soft_s2 <= next_s2;
    end
  end

  // ----------------------------------------------------------------
  // Source level registers
  // ----------------------------------------------------------------
  // Write the low three bits of one nibble; bit 3 reads as zero
  always_comb begin
    next_prio = prio;
    if (prio_wr_en) begin
      next_prio[prio_wr_idx] = prio_wr_data[2:0];
    end
    next_prio_rd = {1'b0, prio[prio_rd_idx]};
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < NSRC; k++) begin
        prio[k] <= `PVIC_PRIO_RST;
      end
      prio_rd_data <= 4'h0;
    end else if (ce) begin
      prio         <= next_prio;
      prio_rd_data <= next_prio_rd;
    end
  end

  // ----------------------------------------------------------------
  // Control and core level
  // ----------------------------------------------------------------
  // Taking an exception raises the core level; hardware beats software
  always_comb begin
    next_alt_sel = alt_sel;
    next_low     = core_priority_low;
    next_top     = core_priority_top;
    if (ctl2_wr_en) begin
      next_alt_sel = ctl2_wr_data[`PVIC_ALT_BIT];
    end
    // Software may write low bits unless nesting is off
    if (ipl_wr_en && !nest_disable) begin
      next_low = ipl_wr_data;
    end
    // Software can only clear the top bit
    if (ipl_top_clr) begin
      next_top = 1'b0;
    end
    // Return restores the saved level
    if (ret_en) begin
      next_low = ret_prio[2:0];
      next_top = ret_prio[3];
    end
    // Accepted exception sets the level so only higher preempts
    if (exc_ack && exc_req) begin
      next_low = exc_level[2:0];
      next_top = exc_level[3] | core_priority_top;     // Trap in progress
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      alt_sel           <= 1'b0;
      core_priority_low <= 3'h0;
      core_priority_top <= 1'b0;
    end else if (ce) begin
      alt_sel           <= next_alt_sel;
      core_priority_low <= next_low;
      core_priority_top <= next_top;
    end
  end

  // ----------------------------------------------------------------
  // Winner and vector address
  // ----------------------------------------------------------------
  // Base of the selected table
  assign base = alt_sel ? `PVIC_ALT_BASE : `PVIC_DEF_BASE;

  // Entries are two apart; traps first, sources after
  always_comb begin
    next_valid = arb.valid;
    next_vec   = arb.win;
    next_lvl   = arb.win_lvl;
    next_addr  = base + {16'h0000, arb.win, 1'b0};
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      win_valid  <= 1'b0;
      exc_vector <= '0;
      exc_addr   <= `PVIC_RESET_ADDR;
      exc_level  <= `PVIC_LVL_NONE;
    end else if (ce) begin
      win_valid  <= next_valid;
      exc_vector <= next_vec;
      exc_addr   <= next_addr;
      exc_level  <= next_lvl;
    end
  end

  // One request to the core, only above the core level
  assign exc_req = win_valid && (exc_level > core_prio);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_ack_taken;
    ce && exc_ack && exc_req;
  endsequence

  sequence s_soft_seen;
    ce && trap_stack_err ##1 ce;
  endsequence

  chk_level_zero_never: assert property (
    @(posedge mclk) disable iff (rst) exc_req |-> exc_level != 4'h0)
    else $error("request with level zero");

  chk_user_below_eight: assert property (
    @(posedge mclk) disable iff (rst)
    exc_req && exc_vector >= VW'(`PVIC_NTRAP) |-> exc_level[3] == 1'b0)
    else $error("user source above level seven");

  chk_ack_raises_core: assert property (
    @(posedge mclk) disable iff (rst)
    s_ack_taken |=> core_prio >= $past(exc_level) &&
                    (!exc_req || exc_level > $past(exc_level)))
    else $error("accepted level not taken by core");

  chk_top_not_sw_set: assert property (
    @(posedge mclk) disable iff (rst)
    $rose(core_priority_top) |->
    $past((exc_ack && exc_req && exc_level[3]) || (ret_en && ret_prio[3])))
    else $error("top level bit set without trap");

  chk_low_locked: assert property (
    @(posedge mclk) disable iff (rst)
    nest_disable && !exc_ack && !ret_en |=> $stable(core_priority_low))
    else $error("low level bits changed while locked");

  chk_soft_two_cyc: assert property (
    @(posedge mclk) disable iff (rst) s_soft_seen |=> soft_s2[0])
    else $error("stack trap not sampled after two cycles");

  chk_addr_table: assert property (
    @(posedge mclk) disable iff (rst)
    $past(ce) && $past(alt_sel) |-> exc_addr == `PVIC_ALT_BASE + {16'h0000, exc_vector, 1'b0})
    else $error("alternate vector address wrong");

  chk_seven_blocks: assert property (
    @(posedge mclk) disable iff (rst)
    core_priority_low == `PVIC_USER_MAX && exc_req |-> exc_vector < VW'(`PVIC_NTRAP))
    else $error("user source taken at level seven");

  chk_idle_no_req: assert property (
    @(posedge mclk) disable iff (rst) ce && !arb.valid |=> !exc_req)
    else $error("request without a pending source");

  chk_rd_bit3_zero: assert property (
    @(posedge mclk) disable iff (rst) prio_rd_data[3] == 1'b0)
    else $error("unused nibble bit read as one");

  chk_trap_sets_top: assert property (
    @(posedge mclk) disable iff (rst) s_ack_taken ##0 exc_level[3] |=> core_priority_top)
    else $error("trap accepted without top level bit");

endmodule : pvic_top
`default_nettype wire

// ---- verification/pvic_core_model.sv ----
// Processor core model that accepts exception requests
`timescale 1ns/1ns
`default_nettype none
module pvic_core_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       auto_ack,  // Accept requests when high
  input  wire logic [3:0] ack_wait,  // Cycles to stall before accepting
  input  wire logic       exc_req,
  output var  logic       exc_ack
);
  logic [3:0] cnt;  // Stall counter
  // ----------------------------------------
  // Acknowledge one cycle, promptly or slowly
  // ----------------------------------------
  always @(negedge mclk or posedge rst) begin
    if (rst) begin
      exc_ack <= 1'b0;
      cnt     <= 4'h0;
    end else if (exc_ack) begin
      // One-cycle pulse, then wait for the next request
      exc_ack <= 1'b0;
      cnt     <= 4'h0;
    end else if (auto_ack && exc_req) begin
      if (cnt >= ack_wait) exc_ack <= 1'b1;
      else cnt <= cnt + 4'h1;
    end else begin
      cnt <= 4'h0;
    end
  end
endmodule : pvic_core_model
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking testbench of the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pvic_pkg::*;
  logic mclk, rst, ce, prio_wr_en, ctl2_wr_en, ipl_wr_en, ipl_top_clr, nest_disable;
  logic exc_ack, ret_en, exc_req, core_priority_top, auto_ack;
  logic [117:0] src_pend;  // Peripheral requests
  logic [3:0]   traps;     // osc, addr, stack, math
  logic [6:0]   prio_wr_idx, prio_rd_idx, exc_vector;
  logic [3:0]   prio_wr_data, prio_rd_data, ret_prio, ack_wait;
  logic [15:0]  ctl2_wr_data, int_control_two;
  logic [2:0]   ipl_wr_data;
  pvic_ulvl_t   core_priority_low;
  pvic_addr_t   exc_addr;
  pvic_lvl_t    exc_level;
  logic [23:0]  restart_addr;
  int num_errors = 0;
  int num_checks = 0;
  int n;
  pvic_top u_dut (.mclk(mclk), .rst(rst), .ce(ce), .src_pend(src_pend),
    .trap_osc_fail(traps[0]), .trap_addr_err(traps[1]), .trap_stack_err(traps[2]),
    .trap_math_err(traps[3]), .prio_wr_en(prio_wr_en), .prio_wr_idx(prio_wr_idx),
    .prio_wr_data(prio_wr_data), .prio_rd_idx(prio_rd_idx), .prio_rd_data(prio_rd_data),
    .ctl2_wr_en(ctl2_wr_en), .ctl2_wr_data(ctl2_wr_data), .int_control_two(int_control_two),
    .ipl_wr_en(ipl_wr_en), .ipl_wr_data(ipl_wr_data), .ipl_top_clr(ipl_top_clr),
    .nest_disable(nest_disable), .core_priority_low(core_priority_low),
    .core_priority_top(core_priority_top), .exc_ack(exc_ack), .ret_en(ret_en),
    .ret_prio(ret_prio), .exc_req(exc_req), .exc_vector(exc_vector),
    .exc_addr(exc_addr), .exc_level(exc_level), .restart_addr(restart_addr));
  pvic_core_model u_core (.mclk(mclk), .rst(rst), .auto_ack(auto_ack),
    .ack_wait(ack_wait), .exc_req(exc_req), .exc_ack(exc_ack));
  // ----------------------------------------
  // Clock, 20 ns period
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // ----------------------------------------
  // Access and check tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask : cyc
  task automatic set_prio(input int i, input logic [3:0] v);
    @(negedge mclk) {prio_wr_en, prio_wr_idx, prio_wr_data} = {1'b1, 7'(i), v};
    @(negedge mclk) prio_wr_en = 1'b0;
  endtask : set_prio
  task automatic wr_ipl(input logic [2:0] v);
    @(negedge mclk) {ipl_wr_en, ipl_wr_data} = {1'b1, v};
    @(negedge mclk) ipl_wr_en = 1'b0;
  endtask : wr_ipl
  task automatic ret(input logic [3:0] v);
    @(negedge mclk) {ret_en, ret_prio} = {1'b1, v};
    @(negedge mclk) ret_en = 1'b0;
  endtask : ret
  task automatic req(input logic [6:0] v, input logic [3:0] l, input logic [23:0] a);
    chk("exc_req", 24'h1, exc_req);
    chk("exc_vector", v, exc_vector);
    chk("exc_level", l, exc_level);
    chk("exc_addr", a, exc_addr);
  endtask : req
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst, ce, src_pend, traps, prio_wr_en, prio_wr_idx, prio_wr_data} = '0;
    {prio_rd_idx, ctl2_wr_en, ctl2_wr_data, ipl_wr_en, ipl_wr_data} = '0;
    {ipl_top_clr, nest_disable, ret_en, ret_prio, auto_ack, ack_wait} = '0;
    rst = 1'b1;
    ce = 1'b1;
    repeat (5) @(posedge mclk);
    @(negedge mclk) rst = 1'b0;
    chk("restart_addr", 24'h000000, restart_addr);
    chk("reset core", 24'h0, {core_priority_top, core_priority_low, exc_req});
    chk("reset ctl2", 24'h0, int_control_two);
    @(negedge mclk) prio_rd_idx = 7'd117;
    cyc(1);
    chk("reset level", 24'h4, prio_rd_data);
    // Single request accepted by the core
    @(negedge mclk) {auto_ack, src_pend[5]} = 2'b11;
    cyc(1);
    req(7'd13, 4'h4, 24'h00001E);
    cyc(1);
    chk("core low", 24'h4, core_priority_low);
    chk("exc_req", 24'h0, exc_req);
    // Same level cannot preempt, higher level can
    @(negedge mclk) src_pend[0] = 1'b1;
    cyc(1);
    chk("same level", 24'h0, exc_req);
    set_prio(1, 4'h5);
    src_pend[1] = 1'b1;
    cyc(1);
    req(7'd9, 4'h5, 24'h000016);
    cyc(1);
    chk("core low", 24'h5, core_priority_low);
    {auto_ack, src_pend} = '0;
    ret(4'h0);
    // Level first, then natural order; level zero disabled
    set_prio(10, 4'h6);
    set_prio(2, 4'h6);
    set_prio(0, 4'h5);
    set_prio(3, 4'h0);
    src_pend[10] = 1'b1;
    src_pend[3:0] = 4'hD;
    cyc(1);
    req(7'd10, 4'h6, 24'h000018);
    src_pend = '0;
    src_pend[3] = 1'b1;
    cyc(2);
    chk("level zero", 24'h0, exc_req);
    src_pend = '0;
    src_pend[117:116] = 2'b11;
    cyc(2);
    req(7'd124, 4'h4, 24'h0000FC);
    @(negedge mclk) {ctl2_wr_en, ctl2_wr_data} = {1'b1, 16'h8000};
    @(negedge mclk) ctl2_wr_en = 1'b0;
    chk("int_control_two", 24'h8000, int_control_two);
    cyc(1);
    req(7'd124, 4'h4, 24'h0001FC);
    @(negedge mclk) {ctl2_wr_en, ctl2_wr_data} = {1'b1, 16'h0000};
    @(negedge mclk) ctl2_wr_en = 1'b0;
    // Core priority must be strictly exceeded
    wr_ipl(3'h4);
    chk("equal level", 24'h0, exc_req);
    wr_ipl(3'h3);
    chk("lower core", 24'h1, exc_req);
    nest_disable = 1'b1;
    wr_ipl(3'h7);
    chk("nest lock", 24'h3, core_priority_low);
    nest_disable = 1'b0;
    wr_ipl(3'h7);
    set_prio(116, 4'h7);
    cyc(1);
    chk("ipl 111", 24'h0, exc_req);
    ce = 1'b0;
    wr_ipl(3'h0);
    chk("ce freeze", 24'h7, core_priority_low);
    ce = 1'b1;
    src_pend = '0;
    ret(4'h0);
    set_prio(20, 4'hF);
    @(negedge mclk) prio_rd_idx = 7'd20;
    cyc(1);
    chk("nibble bit3", 24'h7, prio_rd_data);
    // Each trap: vector, fixed level, sampling delay, top bit
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk) traps[i] = 1'b1;
      n = 1;
      while (exc_req !== 1'b1 && n < 8) begin
        @(negedge mclk);
        n++;
      end
      chk("trap delay", (i < 2) ? 24'h2 : 24'h4, n);
      req(7'(i + 1), 4'(14 - i), 24'(6 + 2 * i));
      {auto_ack, ack_wait} = {1'b1, 4'h2};
      n = 0;
      while (core_priority_top !== 1'b1 && n < 20) begin
        @(negedge mclk);
        n++;
      end
      if (n == 20) begin
        num_errors++;
        $display("Error trap ack wait expected 1 seen timeout");
        test_done();
      end
      chk("trap low", 24'(6 - i), core_priority_low);
      {auto_ack, traps} = '0;
      @(negedge mclk) ipl_top_clr = 1'b1;
      @(negedge mclk) ipl_top_clr = 1'b0;
      chk("top clear", 24'h0, core_priority_top);
      ret(4'h0);
    end
    test_done();
  end
endmodule : tb_top
`default_nettype wire
